//--- bench/test_usb_endpoint_irq_summary.sv
// Directed Wishbone tests for the endpoint irq summary block
`timescale 1ns/1ns
module test_usb_endpoint_irq_summary;
   logic                      sys_clk, arst_n, irq;
   ep_irq_pkg::wb_req_t       req;
   ep_irq_pkg::wb_rsp_t       rsp;
   ep_irq_pkg::ep_src_t [6:0] src;
   logic [7:0]                q;
   int                        error_cnt, comparisons;
   usb_endpoint_irq_summary u_dut (.SYS_CLK(sys_clk), .ARST_N(arst_n), .WB_REQ(req),
      .WB_RSP(rsp), .EP_SRC(src), .USB_IRQ(irq));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One classic cycle; waits for ack, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      req <= '{1'b1, 1'b1, w, a, 1'b1, d};
      do begin
         @(posedge sys_clk);
      end while (rsp.ack !== 1'b1);
      q = rsp.dat;
      req <= '0;
      @(posedge sys_clk);
   endtask
   task automatic test_done;
      $display("Counts: %0d compares, %0d mismatches", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      error_cnt++;
      test_done();
   end
   initial begin
      arst_n = 1'b0;
      req = '0;
      src = '0;
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      wb(1'b0, ep_irq_pkg::SUMMARY_ADDR, 8'h00);
      chk(q, ep_irq_pkg::SUMMARY_RESET);
      wb(1'b0, ep_irq_pkg::ENABLE_ADDR, 8'h00);
      chk(q, ep_irq_pkg::ENABLE_RESET);
      wb(1'b1, ep_irq_pkg::SUMMARY_ADDR, 8'h7f);
      wb(1'b0, ep_irq_pkg::SUMMARY_ADDR, 8'h00);
      chk(q, 8'h00);
      wb(1'b0, 8'h33, 8'h00);
      chk(q, 8'h00);
      $display("test reset and access done");
      for (int e = 0; e < 7; e++) begin
         for (int b = 0; b < 5; b++) begin
            src[e][b] <= 1'b1;
            repeat (3) @(posedge sys_clk);
            wb(1'b0, ep_irq_pkg::SUMMARY_ADDR, 8'h00);
            chk(q, 8'h01 << e);
            chk({7'h00, irq}, 8'h00);
            src[e][b] <= 1'b0;
            repeat (3) @(posedge sys_clk);
            wb(1'b0, ep_irq_pkg::SUMMARY_ADDR, 8'h00);
            chk(q, 8'h00);
         end
      end
      $display("test sources done");
      wb(1'b1, ep_irq_pkg::ENABLE_ADDR, 8'h10);
      wb(1'b0, ep_irq_pkg::ENABLE_ADDR, 8'h00);
      chk(q, 8'h10);
      src[3] <= 5'h1f;
      repeat (3) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h00);
      src[4][4] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h01);
      wb(1'b0, ep_irq_pkg::SUMMARY_ADDR, 8'h00);
      chk(q, 8'h18);
      wb(1'b1, ep_irq_pkg::ENABLE_ADDR, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h00);
      $display("test enable done");
      wb(1'b1, ep_irq_pkg::ENABLE_ADDR, 8'h7f);
      chk({7'h00, irq}, 8'h01);
      arst_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h00);
      arst_n <= 1'b1;
      wb(1'b0, ep_irq_pkg::ENABLE_ADDR, 8'h00);
      chk(q, ep_irq_pkg::ENABLE_RESET);
      wb(1'b0, ep_irq_pkg::SUMMARY_ADDR, 8'h00);
      chk(q, 8'h18);
      chk({7'h00, irq}, 8'h00);
      $display("test mid-run reset done");
      test_done();
   end
endmodule

//--- verilog/ep_irq_pkg.sv
// Package: register map, field layout and bus carrier types for the endpoint irq summary
package ep_irq_pkg;
   localparam int          NUM_EP         = 7;
   localparam int          SRC_W          = 5;
   localparam logic [7:0]  SUMMARY_ADDR   = 8'hf8;
   localparam logic [7:0]  ENABLE_ADDR    = 8'hc2;
   localparam logic [7:0]  SUMMARY_RESET  = 8'h00;
   localparam logic [7:0]  ENABLE_RESET   = 8'h00;
   localparam int          RSVD_BIT       = 7;
   // Source bit positions within one endpoint's status field
   localparam int          SRC_TRANSMIT_COMPLETE      = 0;
   localparam int          SRC_RXB0       = 1;
   localparam int          SRC_RXB1       = 2;
   localparam int          SRC_SETUP      = 3;
   localparam int          SRC_STALLCRC   = 4;

   typedef struct packed {
      logic       cyc;
      logic       stb;
      logic       we;
      logic [7:0] adr;
      logic [0:0] sel;
      logic [7:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic       ack;
      logic [7:0] dat;
   } wb_rsp_t;

   typedef logic [SRC_W-1:0] ep_src_t;
endpackage

//--- verilog/usb_endpoint_irq_summary.sv
// Endpoint interrupt summary flags, enable mask and irq line behind a Wishbone slave
// How it works
// RL1: bit 7 of summary reads zero always
// RL2: flag n set when endpoint n source active
// RL3: sources: transmit_complete, rx bank0/1, setup, stall/crc
// RL4: irq per endpoint needs flag and enable
// RL5: flag self-clears; no software clear path
// RL6: summary at F8h, read-only, resets 00h
// RL7: enable register at C2h, bit per endpoint
// RL8: irq is OR of flag AND enable
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
module usb_endpoint_irq_summary (
   input  wire logic                                    SYS_CLK,   // 10 MHz clock
   input  wire logic                                    ARST_N,    // Async reset, low
   input  wire ep_irq_pkg::wb_req_t                     WB_REQ,    // Wishbone request
   output      ep_irq_pkg::wb_rsp_t                     WB_RSP,    // Wishbone answer
   input  wire ep_irq_pkg::ep_src_t [ep_irq_pkg::NUM_EP-1:0] EP_SRC, // Status sources
   output      logic                                    USB_IRQ    // Endpoint irq, high
);
   logic [ep_irq_pkg::NUM_EP-1:0] flag_r,   flag_nxt;
   logic [ep_irq_pkg::NUM_EP-1:0] enable_r, enable_nxt;
   logic                          irq_r,    irq_nxt;
   logic                          ack_r,    ack_nxt;
   logic [7:0]                    rdat_r,   rdat_nxt;
   logic                          access;
   logic                          rd_summary, rd_enable;
   logic                          wr_summary, wr_enable;

   assign access = WB_REQ.cyc & WB_REQ.stb & ~ack_r;

   always_comb begin
      flag_nxt = '0;
      for (int n = 0; n < ep_irq_pkg::NUM_EP; n++) begin
         // Any status source keeps the flag up; it drops when all clear
         flag_nxt[n] = EP_SRC[n][ep_irq_pkg::SRC_TRANSMIT_COMPLETE]    // [RL2] [RL3] [RL5]
                     | EP_SRC[n][ep_irq_pkg::SRC_RXB0]
                     | EP_SRC[n][ep_irq_pkg::SRC_RXB1]
                     | EP_SRC[n][ep_irq_pkg::SRC_SETUP]
                     | EP_SRC[n][ep_irq_pkg::SRC_STALLCRC];
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         flag_r <= ep_irq_pkg::SUMMARY_RESET[ep_irq_pkg::NUM_EP-1:0]; // [RL6]
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // Irq group: the line is one stage behind the flags, so a source that
   // rises at one edge raises the line two edges later
   always_comb begin
      irq_nxt = |(flag_r & enable_r);                         // [RL4] [RL8]
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // Bus group: registered acknowledge and read data, one answer per request
   always_comb begin
      enable_nxt = enable_r;
      ack_nxt    = access;
      rdat_nxt   = 8'h00;
      if (access && WB_REQ.we && WB_REQ.sel[0]
          && WB_REQ.adr == ep_irq_pkg::ENABLE_ADDR) begin
         enable_nxt = WB_REQ.dat[ep_irq_pkg::NUM_EP-1:0];    // [RL7]
      end
      // Writes to the summary address are dropped
      if (access && !WB_REQ.we) begin
         unique case (WB_REQ.adr)
            ep_irq_pkg::SUMMARY_ADDR: rdat_nxt = {1'b0, flag_r};   // [RL1] [RL6]
            ep_irq_pkg::ENABLE_ADDR:  rdat_nxt = {1'b0, enable_r}; // [RL7]
            default:                  rdat_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         enable_r <= ep_irq_pkg::ENABLE_RESET[ep_irq_pkg::NUM_EP-1:0];
         ack_r    <= 1'b0;
         rdat_r   <= 8'h00;
      end else begin
         enable_r <= enable_nxt;
         ack_r    <= ack_nxt;
         rdat_r   <= rdat_nxt;
      end
   end

   assign WB_RSP.ack = ack_r;
   assign WB_RSP.dat = rdat_r;
   assign USB_IRQ    = irq_r;

   sequence s_src_up(int n);
      |EP_SRC[n];
   endsequence

   a_flag_follows_src: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL2]
      s_src_up(0) |=> flag_r[0])
      else $error("flag 0 not set after source");
   a_flag_self_clear: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL5]
      (EP_SRC[6] == '0) |=> !flag_r[6])
      else $error("flag 6 not cleared");
   a_setup_source: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL3]
      EP_SRC[3][ep_irq_pkg::SRC_SETUP] |=> flag_r[3])
      else $error("setup source ignored");
   a_irq_masked: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL4]
      (enable_r == '0) |=> !USB_IRQ)
      else $error("irq with all enables off");
   a_irq_or_and: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL8]
      1'b1 |=> USB_IRQ == |($past(flag_r) & $past(enable_r)))
      else $error("irq not OR of flag and enable");
   a_rsvd_zero: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL1]
      !rdat_r[ep_irq_pkg::RSVD_BIT])
      else $error("reserved bit read as one");
   a_summary_read: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL6]
      (access && !WB_REQ.we && WB_REQ.adr == ep_irq_pkg::SUMMARY_ADDR)
      |=> ack_r && rdat_r == {1'b0, $past(flag_r)})
      else $error("summary read wrong");
   a_enable_write: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL7]
      (access && WB_REQ.we && WB_REQ.sel[0] && WB_REQ.adr == ep_irq_pkg::ENABLE_ADDR)
      |=> enable_r == $past(WB_REQ.dat[6:0]) ##1 !ack_r)
      else $error("enable write lost");

   // Decode of the request taken this cycle, shared by the bus checks
   always_comb begin
      rd_summary = access && !WB_REQ.we
                   && WB_REQ.adr == ep_irq_pkg::SUMMARY_ADDR;
      rd_enable  = access && !WB_REQ.we
                   && WB_REQ.adr == ep_irq_pkg::ENABLE_ADDR;
      wr_summary = access && WB_REQ.we
                   && WB_REQ.adr == ep_irq_pkg::SUMMARY_ADDR;
      wr_enable  = access && WB_REQ.we && WB_REQ.sel[0]
                   && WB_REQ.adr == ep_irq_pkg::ENABLE_ADDR;
   end

   // Bus answer in two steps: a taken request, then one acknowledge cycle
   sequence s_req_taken;
      access;
   endsequence

   sequence s_ack_pulse;
      ack_r ##1 !ack_r;
   endsequence

   // Endpoint steps: sources all clear, or a flag that its enable lets through
   sequence s_src_clear(int n);
      EP_SRC[n] == '0;
   endsequence

   sequence s_ep_enabled(int n);
      flag_r[n] && enable_r[n];
   endsequence

   a_ack_pulse: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL6] [RL7]
      s_req_taken |=> s_ack_pulse)
      else $error("acknowledge not a single cycle");

   a_ack_only_taken: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL6] [RL7]
      !access |=> !ack_r)
      else $error("acknowledge without a request");

   a_idle_data_zero: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL6]
      !ack_r |-> rdat_r == 8'h00)
      else $error("read data not zero outside acknowledge");

   a_summary_ro: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL6]
      wr_summary |=> ack_r && rdat_r == 8'h00 && $stable(enable_r))
      else $error("summary write had an effect");

   a_write_no_data: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL6]
      (access && WB_REQ.we) |=> rdat_r == 8'h00)
      else $error("write returned read data");

   a_enable_hold: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL7]
      !wr_enable |=> $stable(enable_r))
      else $error("enable register changed without a write");

   a_enable_read: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL7]
      rd_enable |=> ack_r && rdat_r == {1'b0, $past(enable_r)})
      else $error("enable read wrong");

   a_unmapped_read: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL6]
      (access && !WB_REQ.we && !rd_summary && !rd_enable) |=> rdat_r == 8'h00)
      else $error("unmapped read not zero");

   a_irq_quiet: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL8]
      (flag_r & enable_r) == '0 |=> !USB_IRQ)
      else $error("irq with no enabled flag");

   // One copy of the endpoint checks per endpoint, and per source bit
   for (genvar e = 0; e < ep_irq_pkg::NUM_EP; e++) begin : g_ep_chk
      a_flag_set: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL2]
         s_src_up(e) |=> flag_r[e])
         else $error("endpoint flag not set after a source");

      a_flag_clear: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL5]
         s_src_clear(e) |=> !flag_r[e])
         else $error("endpoint flag not cleared with its sources");

      a_flag_cause: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL5]
         flag_r[e] |-> $past(|EP_SRC[e]))
         else $error("endpoint flag set with no source");

      a_irq_from_ep: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL4] [RL8]
         s_src_up(e) ##1 s_ep_enabled(e) |=> USB_IRQ)
         else $error("enabled endpoint flag raised no irq");

      a_enable_bit_set: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL7]
         wr_enable && WB_REQ.dat[e] |=> enable_r[e])
         else $error("enable bit not set by write");

      a_enable_bit_clear: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL7]
         wr_enable && !WB_REQ.dat[e] |=> !enable_r[e])
         else $error("enable bit not cleared by write");

      for (genvar b = 0; b < ep_irq_pkg::SRC_W; b++) begin : g_src_chk
         a_source_bit: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL3]
            EP_SRC[e][b] |=> flag_r[e])
            else $error("status source bit did not reach its flag");
      end
   end
endmodule
